// ---- ipsq_defines.svh ----
`ifndef IPSQ_DEFINES_SVH
`define IPSQ_DEFINES_SVH
// link word layout, opcode travels first
`define IPSQ_W 32
`define IPSQ_OP_LSB 0
`define IPSQ_OP_MSB 7
`define IPSQ_DT_LSB 16
`define IPSQ_DT_MSB 31
// opcodes
`define IPSQ_OP_ENTER 8'h01
`define IPSQ_OP_ID 8'h02
`define IPSQ_OP_ERASE 8'h03
`define IPSQ_OP_PROG 8'h04
`define IPSQ_OP_VERIFY 8'h05
`define IPSQ_OP_EXIT 8'h06
`define IPSQ_OP_STATUS 8'h07
// identity word, value is arbitrary
`define IPSQ_ID_VALUE 32'h5a3c_0e01
// status byte bits
`define IPSQ_ST_BUSY 0
`define IPSQ_ST_MODE 1
`define IPSQ_ST_DONE 2
// configuration store and completion bit address
`define IPSQ_CFG_WORDS 16
`define IPSQ_CFG_AW 4
`define IPSQ_CFG_LIMIT 8'h10
`define IPSQ_CFG_LAST 4'hf
`define IPSQ_ADDR_DONE 8'hff
`define IPSQ_DONE_DATA 16'h0001
// pins and output enable select field
`define IPSQ_N_PINS 8
`define IPSQ_N_GOE 6
`define IPSQ_OE_LSB 0
`define IPSQ_OE_MSB 3
`define IPSQ_OE_LOW 4'h0
`define IPSQ_OE_HIGH 4'h1
`define IPSQ_OE_GOE0 4'h2
// timing
`define IPSQ_CLK_NS 100
`define IPSQ_ENTER_US 1000
`define IPSQ_EXIT_US 1000
`define IPSQ_ERASE_US 100000
`define IPSQ_PROG_US 100
`define IPSQ_READ_US 10
`define IPSQ_WAIT_MARGIN 16
`define IPSQ_CNT_ONE 24'h000001
// link clock divider and frame slots
`define IPSQ_PH_LAST 3'h3
`define IPSQ_SLOT_LEAD_LAST 6'h02
`define IPSQ_SLOT_LAST_BIT 6'h22
`define IPSQ_SLOT_EXEC 6'h23
`endif

// ---- ipsq_pkg.sv ----
`include "ipsq_defines.svh"
`default_nettype none
package ipsq_pkg;
  typedef logic [`IPSQ_W-1:0] ipsq_word_t;
  typedef logic [`IPSQ_OP_MSB:`IPSQ_OP_LSB] ipsq_op_t;
  typedef logic [7:0] ipsq_addr_t;
  typedef logic [`IPSQ_DT_MSB-`IPSQ_DT_LSB:0] ipsq_data_t;
  typedef logic [23:0] ipsq_cnt_t;
  typedef logic [`IPSQ_CFG_AW-1:0] ipsq_cfga_t;
  typedef logic [`IPSQ_N_PINS-1:0] ipsq_pins_t;
  typedef logic [`IPSQ_N_GOE-1:0] ipsq_goe_t;
endpackage
`default_nettype wire

// ---- ipsq_link_if.sv ----
`default_nettype none
interface ipsq_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  modport dev (input tck, input tms, input tdi, output tdo);
  modport host (output tck, output tms, output tdi, input tdo);
endinterface // ipsq_link_if
`default_nettype wire

// ---- ipsq_sync2.sv ----
`default_nettype none
module ipsq_sync2 #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic arst_n,
  // foreign level in, local level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import ipsq_pkg::*;
  logic [W-1:0] s1_reg;
  // first stage is read by the second alone
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_reg <= '0;
      q <= '0;
    end
    else
    begin
      s1_reg <= d;
      q <= s1_reg;
    end
  end
endmodule // ipsq_sync2
`default_nettype wire

// ---- ipsq_device.sv ----
`include "ipsq_defines.svh"
`default_nettype none
module ipsq_device #(
  parameter int unsigned ENTER_CYC = `IPSQ_ENTER_US * 1000 / `IPSQ_CLK_NS,
  parameter int unsigned EXIT_CYC = `IPSQ_EXIT_US * 1000 / `IPSQ_CLK_NS,
  parameter int unsigned ERASE_CYC = `IPSQ_ERASE_US * 1000 / `IPSQ_CLK_NS
) (
  // link from the programming host
  ipsq_link_if.dev lnk,
  // system clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // user logic
  input wire ipsq_pkg::ipsq_pins_t mc_out,
  input wire ipsq_pkg::ipsq_goe_t goe,
  input wire ipsq_pkg::ipsq_pins_t pin_in,
  // pad control
  output ipsq_pkg::ipsq_pins_t pin_out,
  output ipsq_pkg::ipsq_pins_t pin_oe,
  output logic pin_pullup_en,
  // feedback and state
  output ipsq_pkg::ipsq_pins_t pin_fb,
  output ipsq_pkg::ipsq_pins_t mc_fb,
  output logic prog_mode,
  output logic complete
);
  import ipsq_pkg::*;
  localparam int unsigned PROG_CYC = `IPSQ_PROG_US * 1000 / `IPSQ_CLK_NS;
  localparam int unsigned READ_CYC = `IPSQ_READ_US * 1000 / `IPSQ_CLK_NS;
  typedef enum {S_IDLE, S_PULSE} ipsq_dst_t;

  ipsq_word_t sh_reg, sh_next, out_reg, out_next;
  logic tms_d_reg, tms_d_next, rid_reg, rid_next, req_reg, req_next;
  ipsq_op_t cmd_reg, cmd_next, op_in;
  ipsq_addr_t addr_reg, addr_next;
  ipsq_data_t data_reg, data_next;
  logic ack_t, mode_t, done_t, pend, req_s;
  logic [7:0] stat;
  ipsq_dst_t st_reg, st_next;
  ipsq_cnt_t cnt_reg, cnt_next;
  logic seen_reg, seen_next, ack_reg, ack_next;
  logic mode_reg, mode_next, done_reg, done_next, mem_we, mem_clr;
  ipsq_op_t ops_reg, ops_next;
  ipsq_addr_t adrs_reg, adrs_next;
  ipsq_data_t dats_reg, dats_next, rd_reg, rd_next;
  ipsq_data_t mem [`IPSQ_CFG_WORDS];
  ipsq_pins_t pin_in_s, oe_next;

  // levels from the system side, seen on the link clock
  ipsq_sync2 #(.W(3)) u_sync_t (
    .clk(lnk.tck),
    .arst_n(arst_n),
    .d({ack_reg, mode_reg, done_reg}),
    .q({ack_t, mode_t, done_t})
  );

  // a request is outstanding until its toggle comes back
  assign pend = req_reg ^ ack_t;
  assign op_in = sh_reg[`IPSQ_OP_MSB:`IPSQ_OP_LSB];

  // link side: shift in and out, execute on the first low tms tick
  always_comb
  begin
    sh_next = sh_reg;
    out_next = out_reg;
    rid_next = rid_reg;
    req_next = req_reg;
    cmd_next = cmd_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    tms_d_next = lnk.tms;
    stat = '0;
    stat[`IPSQ_ST_BUSY] = pend;
    stat[`IPSQ_ST_MODE] = mode_t;
    stat[`IPSQ_ST_DONE] = done_t;
    if (lnk.tms)
    begin
      sh_next = {lnk.tdi, sh_reg[`IPSQ_W-1:1]}; // [RULE1]
      out_next = {1'b0, out_reg[`IPSQ_W-1:1]};
    end
    else
    begin
      // rd_reg only changes while pend is high, so the word is stable here
      if (rid_reg)
        out_next = `IPSQ_ID_VALUE;
      else
        out_next = {rd_reg, 8'h00, stat};
      if (tms_d_reg)
      begin
        if (op_in == `IPSQ_OP_ID)
          rid_next = 1'b1;
        else if (op_in == `IPSQ_OP_STATUS)
          rid_next = 1'b0;
        else if (!pend) // a command while busy is dropped
        begin
          cmd_next = op_in; // [RULE1]
          addr_next = sh_reg[15:8];
          data_next = sh_reg[`IPSQ_DT_MSB:`IPSQ_DT_LSB];
          req_next = ~req_reg;
          rid_next = 1'b0;
        end
      end
    end
  end

  // link clock registers; the clock stands still outside frames
  always_ff @(posedge lnk.tck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sh_reg <= '0;
      out_reg <= '0;
      rid_reg <= 1'b0;
      req_reg <= 1'b0;
      cmd_reg <= '0;
      addr_reg <= '0;
      data_reg <= '0;
      tms_d_reg <= 1'b0;
    end
    else
    begin
      sh_reg <= sh_next;
      out_reg <= out_next;
      rid_reg <= rid_next;
      req_reg <= req_next;
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      tms_d_reg <= tms_d_next;
    end
  end
  assign lnk.tdo = out_reg[0];

  // request toggle and pad inputs into the system domain
  ipsq_sync2 #(.W(1)) u_sync_req (
    .clk(clk_sys),
    .arst_n(arst_n),
    .d(req_reg),
    .q(req_s)
  );
  ipsq_sync2 #(.W(`IPSQ_N_PINS)) u_sync_pin (
    .clk(clk_sys),
    .arst_n(arst_n),
    .d(pin_in),
    .q(pin_in_s)
  );

  // pulse length per command, timed on the system clock
  function automatic ipsq_cnt_t pulse_len(input ipsq_op_t op);
    case (op)
      `IPSQ_OP_ENTER: pulse_len = ipsq_cnt_t'(ENTER_CYC);
      `IPSQ_OP_EXIT: pulse_len = ipsq_cnt_t'(EXIT_CYC);
      `IPSQ_OP_ERASE: pulse_len = ipsq_cnt_t'(ERASE_CYC);
      `IPSQ_OP_PROG: pulse_len = ipsq_cnt_t'(PROG_CYC);
      `IPSQ_OP_VERIFY: pulse_len = ipsq_cnt_t'(READ_CYC);
      default: pulse_len = `IPSQ_CNT_ONE;
    endcase
  endfunction

  // pulse sequencer on the system clock
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    seen_next = seen_reg;
    ack_next = ack_reg;
    mode_next = mode_reg;
    done_next = done_reg;
    ops_next = ops_reg;
    adrs_next = adrs_reg;
    dats_next = dats_reg;
    rd_next = rd_reg;
    mem_we = 1'b0;
    mem_clr = 1'b0;
    unique case (st_reg)
      S_IDLE:
        if (req_s != seen_reg)
        begin
          seen_next = req_s;
          ops_next = cmd_reg;
          adrs_next = addr_reg;
          dats_next = data_reg;
          if (!mode_reg && cmd_reg != `IPSQ_OP_ENTER)
            ack_next = ~ack_reg; // outside programming mode only entry works
          else
          begin
            st_next = S_PULSE;
            cnt_next = pulse_len(cmd_reg); // [RULE5] [RULE7] [RULE10]
            if (cmd_reg == `IPSQ_OP_ENTER)
              mode_next = 1'b1; // [RULE5] [RULE11]
          end
        end
      S_PULSE:
      begin
        cnt_next = cnt_reg - `IPSQ_CNT_ONE;
        if (cnt_reg == `IPSQ_CNT_ONE)
        begin
          st_next = S_IDLE;
          ack_next = ~ack_reg;
          case (ops_reg)
            `IPSQ_OP_ERASE:
            begin
              mem_clr = 1'b1; // [RULE7]
              done_next = 1'b0; // [RULE21]
            end
            `IPSQ_OP_PROG:
              if (adrs_reg == `IPSQ_ADDR_DONE)
                done_next = 1'b1; // [RULE12]
              else
                mem_we = adrs_reg < `IPSQ_CFG_LIMIT; // [RULE8]
            `IPSQ_OP_VERIFY:
              if (adrs_reg == `IPSQ_ADDR_DONE)
                rd_next = ipsq_data_t'(done_reg);
              else if (adrs_reg < `IPSQ_CFG_LIMIT)
                rd_next = mem[adrs_reg[`IPSQ_CFG_AW-1:0]]; // [RULE9]
              else
                rd_next = '0;
            `IPSQ_OP_EXIT: mode_next = 1'b0; // [RULE10]
            default: ;
          endcase
        end
      end
    endcase
  end

  // output enable per pin: tied low, tied high or one global enable
  always_comb
  begin
    logic [3:0] sel;
    int idx;
    logic en;
    sel = '0;
    idx = 0;
    en = 1'b0;
    oe_next = '0;
    for (int i = 0; i < `IPSQ_N_PINS; i++)
    begin
      sel = mem[i][`IPSQ_OE_MSB:`IPSQ_OE_LSB];
      idx = int'(sel) - int'(`IPSQ_OE_GOE0);
      if (sel == `IPSQ_OE_LOW)
        en = 1'b0; // [RULE17]
      else if (sel == `IPSQ_OE_HIGH)
        en = 1'b1; // [RULE18]
      else if (idx < `IPSQ_N_GOE)
        en = goe[idx]; // [RULE16]
      else
        en = 1'b0;
      // no drive in programming mode or before the completion bit
      oe_next[i] = en & done_reg & ~mode_reg; // [RULE11] [RULE12] [RULE21]
    end
  end

  // store is nonvolatile in spirit, so reset leaves it alone
  always_ff @(posedge clk_sys)
  begin
    if (mem_clr)
      for (int i = 0; i < `IPSQ_CFG_WORDS; i++)
        mem[i] <= '0;
    else if (mem_we)
      mem[adrs_reg[`IPSQ_CFG_AW-1:0]] <= dats_reg;
  end

  // system clock registers and pad flops
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= S_IDLE;
      cnt_reg <= '0;
      seen_reg <= 1'b0;
      ack_reg <= 1'b0;
      mode_reg <= 1'b0;
      done_reg <= 1'b0;
      ops_reg <= '0;
      adrs_reg <= '0;
      dats_reg <= '0;
      rd_reg <= '0;
      pin_out <= '0;
      pin_oe <= '0;
      pin_pullup_en <= 1'b0;
      pin_fb <= '0;
      mc_fb <= '0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      seen_reg <= seen_next;
      ack_reg <= ack_next;
      mode_reg <= mode_next;
      done_reg <= done_next;
      ops_reg <= ops_next;
      adrs_reg <= adrs_next;
      dats_reg <= dats_next;
      rd_reg <= rd_next;
      pin_out <= mc_out;
      pin_oe <= oe_next;
      pin_pullup_en <= mode_next; // [RULE11]
      pin_fb <= pin_in_s; // [RULE19]
      mc_fb <= mc_out; // [RULE19]
    end
  end
  assign prog_mode = mode_reg;
  assign complete = done_reg;
endmodule // ipsq_device
`default_nettype wire

// ---- ipsq_host.sv ----
// Summary of operation
// RULE1: host shifts opcode, address, data in serially
// RULE2: host captures shifted-out response for comparison
// RULE3: full run: enter, id, erase, program, verify, exit
// RULE4: verify-only run skips erase and program
// RULE5: entry moves pins smoothly; host allows 1 ms
// RULE6: identity word checked before program or verify
// RULE7: erase is one 100 ms pulse, waited out
// RULE8: each address and data written by pulse
// RULE9: each address read by pulse, shifted out
// RULE10: exit returns pins smoothly; host allows 1 ms
// RULE11: outputs tristate with pull-up while programming
// RULE12: completion bit last; no drive until set
// RULE13: adaptive host polls status, moves on early
// RULE14: constant host waits fixed times, no poll; code still reads status once after each wait and aborts if busy
// RULE15: older variants need adaptive; others take both
// RULE16: pin enable from one global enable or tied
// RULE17: enable tied low: pin is input only
// RULE18: enable tied high: output always driven
// RULE19: pin and macrocell feedback are independent
// RULE20: stage time is pulse plus shift time
// RULE21: aborted pass leaves outputs undriven after reset
// RULE22: mismatch aborts run, completion bit not written
`include "ipsq_defines.svh"
`default_nettype none
module ipsq_host #(
  parameter int unsigned ENTER_CYC = `IPSQ_ENTER_US * 1000 / `IPSQ_CLK_NS,
  parameter int unsigned EXIT_CYC = `IPSQ_EXIT_US * 1000 / `IPSQ_CLK_NS,
  parameter int unsigned ERASE_CYC = `IPSQ_ERASE_US * 1000 / `IPSQ_CLK_NS
) (
  // link to the device
  ipsq_link_if.host lnk,
  // system clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // run control
  input wire logic start,
  input wire logic verify_only,
  input wire logic adaptive,
  // pattern source, answers in the same cycle
  output ipsq_pkg::ipsq_cfga_t pat_addr,
  input wire ipsq_pkg::ipsq_data_t pat_data,
  // outcome
  output logic busy,
  output logic pass,
  output logic fail
);
  import ipsq_pkg::*;
  localparam int unsigned PROG_CYC = `IPSQ_PROG_US * 1000 / `IPSQ_CLK_NS;
  localparam int unsigned READ_CYC = `IPSQ_READ_US * 1000 / `IPSQ_CLK_NS;
  typedef enum {H_IDLE, H_CMD, H_SEND, H_WAIT, H_POLL} ipsq_hst_t;
  typedef enum {P_ENTER, P_ID, P_ERASE, P_PROG, P_VER, P_DONE, P_EXIT} ipsq_step_t;

  logic fr_go, fr_act_reg, fr_act_next, fr_done_reg, fr_done_next, tdo_s;
  logic tck_reg, tck_next, tms_reg, tms_next, tdi_reg, tdi_next;
  logic [2:0] ph_reg, ph_next;
  logic [5:0] slot_reg, slot_next;
  ipsq_word_t fr_word, txw_reg, txw_next, rx_reg, rx_next, cmd_word;
  ipsq_hst_t hst_reg, hst_next;
  ipsq_step_t step_reg, step_next;
  ipsq_cnt_t wcnt_reg, wcnt_next, wait_len;
  ipsq_cfga_t pa_next;
  logic failp_reg, failp_next, busy_next, pass_next, fail_next, adv, abort;

  // device output arrives on the link clock
  ipsq_sync2 #(.W(1)) u_sync_tdo (
    .clk(clk_sys),
    .arst_n(arst_n),
    .d(lnk.tdo),
    .q(tdo_s)
  );

  // frame: three lead ticks, 32 shift ticks, one execute tick
  // three leads let the ack toggle clear the device's tck synchroniser before status loads
  always_comb
  begin
    fr_act_next = fr_act_reg;
    fr_done_next = 1'b0;
    tck_next = tck_reg;
    tms_next = tms_reg;
    tdi_next = tdi_reg;
    ph_next = ph_reg;
    slot_next = slot_reg;
    txw_next = txw_reg;
    rx_next = rx_reg;
    if (fr_go)
    begin
      fr_act_next = 1'b1;
      tck_next = 1'b0;
      tms_next = 1'b0;
      tdi_next = 1'b0;
      ph_next = '0;
      slot_next = '0;
      txw_next = fr_word;
    end
    else if (fr_act_reg)
    begin
      ph_next = ph_reg + 3'h1;
      if (ph_reg == `IPSQ_PH_LAST)
      begin
        // divider makes the link clock; data moves on its falling edge
        ph_next = '0;
        tck_next = ~tck_reg;
        if (tck_reg && slot_reg == `IPSQ_SLOT_EXEC)
        begin
          fr_act_next = 1'b0;
          fr_done_next = 1'b1;
        end
        else if (tck_reg)
        begin
          slot_next = slot_reg + 6'h01;
          tms_next = slot_reg >= `IPSQ_SLOT_LEAD_LAST && slot_reg < `IPSQ_SLOT_LAST_BIT;
          if (tms_next)
          begin
            tdi_next = txw_reg[0]; // [RULE1]
            txw_next = {1'b0, txw_reg[`IPSQ_W-1:1]};
            rx_next = {tdo_s, rx_reg[`IPSQ_W-1:1]}; // [RULE2]
          end
        end
      end
    end
  end

  // command word for each stage
  always_comb
  begin
    cmd_word = '0;
    unique case (step_reg)
      P_ENTER: cmd_word[`IPSQ_OP_MSB:`IPSQ_OP_LSB] = `IPSQ_OP_ENTER;
      P_ID: cmd_word[`IPSQ_OP_MSB:`IPSQ_OP_LSB] = `IPSQ_OP_ID;
      P_ERASE: cmd_word[`IPSQ_OP_MSB:`IPSQ_OP_LSB] = `IPSQ_OP_ERASE;
      P_PROG: cmd_word = {pat_data, ipsq_addr_t'(pat_addr), `IPSQ_OP_PROG}; // [RULE8]
      P_VER: cmd_word = {16'h0000, ipsq_addr_t'(pat_addr), `IPSQ_OP_VERIFY}; // [RULE9]
      P_DONE: cmd_word = {`IPSQ_DONE_DATA, `IPSQ_ADDR_DONE, `IPSQ_OP_PROG}; // [RULE12]
      P_EXIT: cmd_word[`IPSQ_OP_MSB:`IPSQ_OP_LSB] = `IPSQ_OP_EXIT;
    endcase
  end

  // adaptive polls at once; constant waits the full pulse and margin
  always_comb
  begin
    wait_len = `IPSQ_CNT_ONE; // [RULE13] [RULE15]
    if (!adaptive) // [RULE14]
      unique case (step_reg)
        P_ENTER: wait_len = ipsq_cnt_t'(ENTER_CYC + `IPSQ_WAIT_MARGIN); // [RULE5] [RULE20]
        P_EXIT: wait_len = ipsq_cnt_t'(EXIT_CYC + `IPSQ_WAIT_MARGIN); // [RULE10] [RULE20]
        P_ERASE: wait_len = ipsq_cnt_t'(ERASE_CYC + `IPSQ_WAIT_MARGIN); // [RULE7] [RULE20]
        P_PROG, P_DONE: wait_len = ipsq_cnt_t'(PROG_CYC + `IPSQ_WAIT_MARGIN);
        P_VER: wait_len = ipsq_cnt_t'(READ_CYC + `IPSQ_WAIT_MARGIN);
        P_ID: wait_len = `IPSQ_CNT_ONE;
      endcase
  end

  // stage sequencer
  always_comb
  begin
    hst_next = hst_reg;
    step_next = step_reg;
    wcnt_next = wcnt_reg;
    pa_next = pat_addr;
    failp_next = failp_reg;
    busy_next = busy;
    pass_next = pass;
    fail_next = fail;
    fr_go = 1'b0;
    fr_word = cmd_word;
    adv = 1'b0;
    abort = 1'b0;
    unique case (hst_reg)
      H_IDLE:
        if (start)
        begin
          busy_next = 1'b1;
          pass_next = 1'b0;
          fail_next = 1'b0;
          failp_next = 1'b0;
          pa_next = '0;
          step_next = P_ENTER; // [RULE3] [RULE4]
          hst_next = H_CMD;
        end
      H_CMD:
      begin
        fr_go = 1'b1;
        hst_next = H_SEND;
      end
      H_SEND:
        if (fr_done_reg)
        begin
          wcnt_next = wait_len;
          hst_next = H_WAIT;
        end
      H_WAIT:
      begin
        wcnt_next = wcnt_reg - `IPSQ_CNT_ONE;
        if (wcnt_reg == `IPSQ_CNT_ONE)
        begin
          fr_go = 1'b1;
          fr_word = '0;
          fr_word[`IPSQ_OP_MSB:`IPSQ_OP_LSB] = `IPSQ_OP_STATUS;
          hst_next = H_POLL;
        end
      end
      H_POLL:
        if (fr_done_reg)
        begin
          if (step_reg == P_ID)
          begin
            abort = rx_reg != `IPSQ_ID_VALUE; // [RULE6] [RULE22]
            adv = !abort;
          end
          else if (rx_reg[`IPSQ_ST_BUSY])
          begin
            abort = !adaptive; // [RULE14]
            wcnt_next = `IPSQ_CNT_ONE;
            hst_next = adaptive ? H_WAIT : hst_reg; // [RULE13]
          end
          else if (step_reg == P_VER)
          begin
            abort = rx_reg[`IPSQ_DT_MSB:`IPSQ_DT_LSB] != pat_data; // [RULE2] [RULE22]
            adv = !abort;
          end
          else
            adv = 1'b1;
        end
    endcase
    // mismatch: leave programming mode, never write the completion bit
    if (abort && step_reg == P_EXIT)
    begin
      hst_next = H_IDLE;
      busy_next = 1'b0;
      fail_next = 1'b1;
    end
    else if (abort)
    begin
      failp_next = 1'b1; // [RULE22]
      step_next = P_EXIT;
      hst_next = H_CMD;
    end
    if (adv)
    begin
      hst_next = H_CMD;
      unique case (step_reg)
        P_ENTER: step_next = P_ID;
        P_ID: step_next = verify_only ? P_VER : P_ERASE; // [RULE4]
        P_ERASE: step_next = P_PROG;
        P_PROG, P_VER:
        begin
          pa_next = pat_addr + 4'h1;
          if (pat_addr == `IPSQ_CFG_LAST)
          begin
            pa_next = '0;
            if (step_reg == P_PROG)
              step_next = P_VER;
            else
              step_next = verify_only ? P_EXIT : P_DONE; // [RULE3] [RULE12]
          end
        end
        P_DONE: step_next = P_EXIT;
        P_EXIT:
        begin
          hst_next = H_IDLE;
          busy_next = 1'b0;
          pass_next = !failp_reg;
          fail_next = failp_reg;
        end
      endcase
    end
  end

  // all state and every output registered here
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fr_act_reg <= 1'b0;
      fr_done_reg <= 1'b0;
      tck_reg <= 1'b0;
      tms_reg <= 1'b0;
      tdi_reg <= 1'b0;
      ph_reg <= '0;
      slot_reg <= '0;
      txw_reg <= '0;
      rx_reg <= '0;
      hst_reg <= H_IDLE;
      step_reg <= P_ENTER;
      wcnt_reg <= '0;
      pat_addr <= '0;
      failp_reg <= 1'b0;
      busy <= 1'b0;
      pass <= 1'b0;
      fail <= 1'b0;
    end
    else
    begin
      fr_act_reg <= fr_act_next;
      fr_done_reg <= fr_done_next;
      tck_reg <= tck_next;
      tms_reg <= tms_next;
      tdi_reg <= tdi_next;
      ph_reg <= ph_next;
      slot_reg <= slot_next;
      txw_reg <= txw_next;
      rx_reg <= rx_next;
      hst_reg <= hst_next;
      step_reg <= step_next;
      wcnt_reg <= wcnt_next;
      pat_addr <= pa_next;
      failp_reg <= failp_next;
      busy <= busy_next;
      pass <= pass_next;
      fail <= fail_next;
    end
  end
  assign lnk.tck = tck_reg;
  assign lnk.tms = tms_reg;
  assign lnk.tdi = tdi_reg;
endmodule // ipsq_host
`default_nettype wire

// ---- ipsq_assertions.sv ----
`default_nettype none
module ipsq_checker (
  // clock, reset and link
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  // device pads and state
  input wire logic prog_mode,
  input wire ipsq_pkg::ipsq_pins_t pin_oe,
  input wire logic pin_pullup_en,
  input wire logic complete
);
  timeunit 1ns;
  timeprecision 1ns;
  import ipsq_pkg::*;
  logic [8:0] sh_cnt_reg;
  logic [8:0] sh_cnt_next;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  // clk cycles of shift ticks in this frame
  always_comb
  begin
    sh_cnt_next = tms ? sh_cnt_reg + 9'h001 : 9'h000;
  end
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      sh_cnt_reg <= 9'h000;
    else
      sh_cnt_reg <= sh_cnt_next;
  end
  sequence tck_hi4;
    tck [*4] ##1 !tck;
  endsequence
  chk_tck_shape: assert property ($rose(tck) |-> tck_hi4)
    else $error("tck high time wrong");
  chk_shift_len: assert property ($fell(tms) |-> sh_cnt_reg == 9'h100)
    else $error("frame shift length wrong");
  chk_tms_edge: assert property ($changed(tms) || $changed(tdi) |-> $fell(tck))
    else $error("tms or tdi moved off tck fall");
  chk_tdo_edge: assert property ($changed(tdo) |-> $rose(tck))
    else $error("tdo moved off tck rise");
  chk_prog_hiz: assert property (prog_mode && $past(prog_mode) |->
    pin_oe == 8'h00 && pin_pullup_en)
    else $error("pins driven in programming");
  chk_enter_pins: assert property ($rose(prog_mode) |=> pin_oe == 8'h00 && pin_pullup_en)
    else $error("entry not tristated");
  chk_exit_pins: assert property ($fell(prog_mode) |=> !pin_pullup_en)
    else $error("pull-up kept after exit");
  chk_done_gate: assert property (!complete && !$past(complete) |-> pin_oe == 8'h00)
    else $error("pins driven before completion");
  chk_done_mode: assert property ($rose(complete) |-> prog_mode)
    else $error("completion set outside programming");
endmodule // ipsq_checker
`default_nettype wire

// ---- isp_programming_sequencer_tb.sv ----
`default_nettype none
module isp_programming_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ipsq_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic vo = 1'b0;
  logic ad = 1'b1;
  logic bad = 1'b0;
  ipsq_pins_t mc_out = 8'h00;
  ipsq_goe_t goe = 6'h00;
  ipsq_pins_t ext = 8'h00;
  ipsq_pins_t pin_in, pin_out, pin_oe, pin_fb, mc_fb;
  ipsq_cfga_t pat_addr;
  ipsq_data_t pat_data;
  logic pin_pullup_en, prog_mode, complete, busy, pass, fail;
  int failures = 0;
  int compares = 0;
  ipsq_link_if lnk ();
  always #50 clk_sys = ~clk_sys;
  // word i selects enable code i; bad flips bit0 so verify must miss
  assign pat_data = {12'h000, pat_addr} ^ {15'h0000, bad};
  // pad: driven, else pull-up in programming, else board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pullup_en ? 8'hff : ext));
  // host erase wait keeps its full length: only a constant full run would use it
  ipsq_host #(.ENTER_CYC(20), .EXIT_CYC(20)) ipsq_host_i (.lnk(lnk),
    .clk_sys(clk_sys), .arst_n(arst_n), .start(start), .verify_only(vo), .adaptive(ad),
    .pat_addr(pat_addr), .pat_data(pat_data), .busy(busy), .pass(pass), .fail(fail));
  ipsq_device #(.ENTER_CYC(20), .EXIT_CYC(20), .ERASE_CYC(50)) ipsq_device_i (.lnk(lnk),
    .clk_sys(clk_sys), .arst_n(arst_n), .mc_out(mc_out), .goe(goe), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .pin_fb(pin_fb),
    .mc_fb(mc_fb), .prog_mode(prog_mode), .complete(complete));
  ipsq_checker ipsq_checker_i (.clk_sys(clk_sys), .arst_n(arst_n), .tck(lnk.tck),
    .tms(lnk.tms), .tdi(lnk.tdi), .tdo(lnk.tdo), .prog_mode(prog_mode), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .complete(complete));
  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one pulse of start, then a bounded wait for busy to drop
  task automatic run(input logic v, input logic a);
    int n;
    n = 0;
    @(negedge clk_sys);
    vo = v;
    ad = a;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    while (busy !== 1'b0 && n < 60000)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 60000)
    begin
      failures++;
      test_done();
    end
  endtask
  initial
  begin
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    chk("pin_oe", 8'h00, pin_oe);
    mc_out = 8'hc3;
    ext = 8'h5a;
    goe = 6'h2d;
    repeat (5) @(negedge clk_sys);
    chk("mc_fb", 8'hc3, mc_fb);
    chk("pin_fb", 8'h5a, pin_fb);
    run(1'b0, 1'b1);
    chk("result", 8'h01, {6'h00, fail, pass});
    chk("complete", 8'h01, {7'h00, complete});
    chk("pin_oe", {6'h2d, 2'b10}, pin_oe);
    goe = 6'h12;
    repeat (6) @(negedge clk_sys);
    chk("pin_oe", {6'h12, 2'b10}, pin_oe);
    chk("pin_fb", (8'h4a & 8'hc3) | (~8'h4a & 8'h5a), pin_fb);
    run(1'b1, 1'b0);
    chk("result", 8'h01, {6'h00, fail, pass});
    @(negedge clk_sys);
    arst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    bad = 1'b1;
    run(1'b1, 1'b1);
    chk("result", 8'h02, {6'h00, fail, pass});
    chk("complete", 8'h00, {7'h00, complete});
    chk("pin_oe", 8'h00, pin_oe);
    test_done();
  end
endmodule // isp_programming_sequencer_tb
`default_nettype wire
